// File: logic/i2cms_core.sv
// Master start generation, bus condition detection and arbitration for the two-wire port.
// Contract
// - Start request with idle bus loads seven-bit reload.
// - Period expiry with lines high drives data low.
// - Data falling while clock high sets start-detected.
// - Reload eight bits, then clear start request.
// - Start done: suspend generator, hold data low.
// - Low lines at start set collision, abort.
// - Buffer write during start sets write clash.
// - Sequence bits ignored unless port idle and enabled.
// - Sleep with interrupts enabled: slave byte or match wakes processor.
// - Reset disables port, ends transfer.
// - Reset or disable clears start, stop flags.
// - Start and stop detection raise event flag.
// - Released one read low sets collision.
// - Arbitration covers start request, start wait and transmit into collision flag.
// - Collision in transmit: halt, clear full, release.
// - Collision in sequence: abort, release, clear request.
// - After collision, stop sets serial event flag.
// - New buffer write restarts from first bit.
// - Non-idle port refuses requests; buffer writes refused during start or transmit.
`timescale 1ns/100ps
module i2cms_core #(
  parameter int ADDR_W = 3
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Bus data line.
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Bus clock line.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  // Slave receive events and wake request.
  input wire logic slave_match_i,
  input wire logic slave_byte_i,
  output logic wake_o
);

  typedef struct packed {
    logic [1:0] sda_s;
    logic [1:0] scl_s;
    logic sda_p;
    logic scl_p;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] reload;
    logic [7:0] buffer;
    logic [7:0] shift;
    logic [2:0] bitn;
    logic full;
    logic sflag;
    logic pflag;
    logic coll;
    logic wclash;
    logic event_f;
    logic wake;
    logic [7:0] brg;
    logic brg_run;
    logic sda_low;
    logic [7:0] rdata;
    logic [1:0] settle;
    i2cms_pkg::i2cms_state_t st;
  } i2cms_regs_t;

  i2cms_regs_t q, d;

  logic sda, scl, en, tick, start_seen, stop_seen;

  assign sda = q.sda_s[1];
  assign scl = q.scl_s[1];
  assign en = q.ctrl1[i2cms_pkg::CTRL1_ENABLE];
  assign tick = q.brg_run && (q.brg == 8'h00);
  assign start_seen = q.sda_p && !sda && q.scl_p && scl;
  assign stop_seen = !q.sda_p && sda && q.scl_p && scl;

  always_comb
  begin
    d = q;
    d.sda_s = {q.sda_s[0], sda_i};
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_p = sda;
    d.scl_p = scl;
    d.rdata = 8'h00;
    if (q.brg_run && q.brg != 8'h00)
    begin
      d.brg = q.brg - 8'h01;
    end
    if (start_seen)
    begin
      d.sflag = 1'b1;
      d.pflag = 1'b0;
    end
    if (stop_seen)
    begin
      d.pflag = 1'b1;
      d.sflag = 1'b0;
    end
    // Register reads.
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        i2cms_pkg::ADDR_CTRL1: d.rdata = q.ctrl1;
        i2cms_pkg::ADDR_CTRL2: d.rdata = q.ctrl2;
        i2cms_pkg::ADDR_STATUS:
        begin
          d.rdata[i2cms_pkg::STAT_FULL] = q.full;
          d.rdata[i2cms_pkg::STAT_START] = q.sflag;
          d.rdata[i2cms_pkg::STAT_STOP] = q.pflag;
        end
        i2cms_pkg::ADDR_RELOAD: d.rdata = q.reload;
        i2cms_pkg::ADDR_BUF: d.rdata = q.buffer;
        i2cms_pkg::ADDR_FLAGS:
        begin
          d.rdata[i2cms_pkg::FLAG_COLL] = q.coll;
          d.rdata[i2cms_pkg::FLAG_WCLASH] = q.wclash;
          d.rdata[i2cms_pkg::FLAG_EVENT] = q.event_f;
          d.rdata[i2cms_pkg::FLAG_WAKE] = q.wake;
        end
        default: d.rdata = 8'h00;
      endcase
    end
    // Register writes; flags clear by writing a one.
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        i2cms_pkg::ADDR_CTRL1: d.ctrl1 = reg_wdata_i;
        i2cms_pkg::ADDR_CTRL2:
        begin
          d.ctrl2[7:i2cms_pkg::CTRL2_SEQ_W] = reg_wdata_i[7:i2cms_pkg::CTRL2_SEQ_W];
          if (q.st == i2cms_pkg::I2CMS_IDLE && en)
          begin
            d.ctrl2[i2cms_pkg::CTRL2_SEQ_W-1:0] = reg_wdata_i[i2cms_pkg::CTRL2_SEQ_W-1:0];
          end
        end
        i2cms_pkg::ADDR_RELOAD: d.reload = reg_wdata_i;
        i2cms_pkg::ADDR_BUF:
        begin
          if (q.st == i2cms_pkg::I2CMS_SWAIT || q.st == i2cms_pkg::I2CMS_SHOLD)
          begin
            d.wclash = 1'b1;
          end
          else if (q.st == i2cms_pkg::I2CMS_TX)
          begin
            d.wclash = 1'b1;
          end
          else
          begin
            d.buffer = reg_wdata_i;
            d.shift = reg_wdata_i;
            d.bitn = 3'h7;
            d.full = 1'b1;
          end
        end
        i2cms_pkg::ADDR_FLAGS:
        begin
          if (reg_wdata_i[i2cms_pkg::FLAG_COLL]) d.coll = 1'b0;
          if (reg_wdata_i[i2cms_pkg::FLAG_WCLASH]) d.wclash = 1'b0;
          if (reg_wdata_i[i2cms_pkg::FLAG_EVENT]) d.event_f = 1'b0;
          if (reg_wdata_i[i2cms_pkg::FLAG_WAKE]) d.wake = 1'b0;
        end
        default: d.rdata = 8'h00;
      endcase
    end
    // Hardware sets win over software clears.
    if (start_seen || stop_seen)
    begin
      d.event_f = 1'b1;
    end
    if ((slave_match_i || slave_byte_i) && q.ctrl1[i2cms_pkg::CTRL1_SLEEP]
        && q.ctrl1[i2cms_pkg::CTRL1_IRQ_EN])
    begin
      d.wake = 1'b1;
    end
    // Sequencer.
    unique case (q.st)
      i2cms_pkg::I2CMS_IDLE, i2cms_pkg::I2CMS_HELD:
      begin
        if (q.st == i2cms_pkg::I2CMS_IDLE && d.ctrl2[i2cms_pkg::CTRL2_START] && en)
        begin
          if (sda && scl)
          begin
            d.brg = {1'b0, q.reload[i2cms_pkg::RELOAD_FIRST_W-1:0]};
            d.brg_run = 1'b1;
            d.st = i2cms_pkg::I2CMS_SWAIT;
          end
          else
          begin
            d.coll = 1'b1;
            d.ctrl2[i2cms_pkg::CTRL2_START] = 1'b0;
          end
        end
        else if (q.st == i2cms_pkg::I2CMS_HELD && q.full && en)
        begin
          d.st = i2cms_pkg::I2CMS_TX;
          d.brg = q.reload;
          d.brg_run = 1'b1;
        end
      end
      i2cms_pkg::I2CMS_SWAIT:
      begin
        if (!scl)
        begin
          d.coll = 1'b1;
          d.ctrl2[i2cms_pkg::CTRL2_START] = 1'b0;
          d.brg_run = 1'b0;
          d.st = i2cms_pkg::I2CMS_IDLE;
        end
        else if (tick && sda)
        begin
          d.sda_low = 1'b1;
          d.brg = q.reload[i2cms_pkg::RELOAD_W-1:0];
          d.st = i2cms_pkg::I2CMS_SHOLD;
        end
        else if (tick)
        begin
          d.coll = 1'b1;
          d.ctrl2[i2cms_pkg::CTRL2_START] = 1'b0;
          d.brg_run = 1'b0;
          d.st = i2cms_pkg::I2CMS_IDLE;
        end
      end
      i2cms_pkg::I2CMS_SHOLD:
      begin
        if (tick)
        begin
          d.ctrl2[i2cms_pkg::CTRL2_START] = 1'b0;
          d.brg_run = 1'b0;
          d.st = i2cms_pkg::I2CMS_HELD;
        end
      end
      i2cms_pkg::I2CMS_TX:
      begin
        d.sda_low = !q.shift[q.bitn];
        // A released one is only judged once the synchronised line has settled.
        if (q.shift[q.bitn] && !q.sda_low && q.settle == 2'h3 && scl && !sda)
        begin
          d.coll = 1'b1;
          d.full = 1'b0;
          d.sda_low = 1'b0;
          d.brg_run = 1'b0;
          d.st = i2cms_pkg::I2CMS_IDLE;
        end
        else if (tick)
        begin
          d.brg = q.reload;
          if (q.bitn == 3'h0)
          begin
            d.full = 1'b0;
            d.brg_run = 1'b0;
            d.st = i2cms_pkg::I2CMS_HELD;
          end
          else
          begin
            d.bitn = q.bitn - 3'h1;
          end
        end
      end
      default:
      begin
        d.st = i2cms_pkg::I2CMS_IDLE;
        d.brg_run = 1'b0;
      end
    endcase
    if (d.st == i2cms_pkg::I2CMS_IDLE && q.st != i2cms_pkg::I2CMS_IDLE)
    begin
      d.sda_low = 1'b0;
    end
    if (!en)
    begin
      d.sflag = 1'b0;
      d.pflag = 1'b0;
      d.st = i2cms_pkg::I2CMS_IDLE;
      d.brg_run = 1'b0;
      d.sda_low = 1'b0;
      d.ctrl2[i2cms_pkg::CTRL2_SEQ_W-1:0] = '0;
    end
    // Counts the cycles since the data drive last changed.
    if (d.sda_low != q.sda_low)
    begin
      d.settle = 2'h0;
    end
    else if (q.settle != 2'h3)
    begin
      d.settle = q.settle + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.sda_s <= 2'b11;
      q.scl_s <= 2'b11;
      q.sda_p <= 1'b1;
      q.scl_p <= 1'b1;
      q.ctrl1 <= i2cms_pkg::CTRL_RST;
      q.ctrl2 <= i2cms_pkg::CTRL_RST;
      q.reload <= i2cms_pkg::RELOAD_RST;
      q.st <= i2cms_pkg::I2CMS_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !q.sda_low;
  assign scl_o = 1'b0;
  assign scl_oe_n_o = 1'b1;
  assign wake_o = q.wake;

endmodule // i2cms_core

// File: common/i2cms_pkg.sv
// Package of constants and types for the two-wire master start and arbitration block.
package i2cms_pkg;
  // Register addresses.
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_RELOAD = 3'h3;
  localparam logic [2:0] ADDR_BUF = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  // Control register one fields.
  localparam int CTRL1_ENABLE = 0;
  localparam int CTRL1_IRQ_EN = 1;
  localparam int CTRL1_SLEEP = 2;
  // Control register two fields.
  localparam int CTRL2_START = 0;
  localparam int CTRL2_RSTART = 1;
  localparam int CTRL2_STOP = 2;
  localparam int CTRL2_RECV = 3;
  localparam int CTRL2_ACK = 4;
  localparam int CTRL2_SEQ_W = 5;
  // Status register fields.
  localparam int STAT_FULL = 0;
  localparam int STAT_START = 3;
  localparam int STAT_STOP = 4;
  // Flag register fields.
  localparam int FLAG_COLL = 0;
  localparam int FLAG_WCLASH = 1;
  localparam int FLAG_EVENT = 2;
  localparam int FLAG_WAKE = 3;
  // Reset values.
  localparam logic [7:0] RELOAD_RST = 8'h09;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Reload field widths.
  localparam int RELOAD_FIRST_W = 7;
  localparam int RELOAD_W = 8;

  typedef enum logic [2:0] {
    I2CMS_IDLE = 3'b000,
    I2CMS_SWAIT = 3'b001,
    I2CMS_SHOLD = 3'b011,
    I2CMS_HELD = 3'b010,
    I2CMS_TX = 3'b110
  } i2cms_state_t;
endpackage

// File: sim/i2cms_checker.sv
// Assertion checker for the start and arbitration core.
`timescale 1ns/100ps
module i2cms_checker (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  // Bus lines and slave events.
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire logic slave_match_i,
  input wire logic slave_byte_i,
  input wire logic wake_o
);
  logic [7:0] c1_q;
  logic [7:0] rl_q;
  logic [7:0] cnt_q;
  // Shadows of control one and reload, and cycles since the last start request.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      c1_q <= i2cms_pkg::CTRL_RST;
      rl_q <= i2cms_pkg::RELOAD_RST;
      cnt_q <= 8'hff;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == i2cms_pkg::ADDR_CTRL1)
        c1_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == i2cms_pkg::ADDR_RELOAD)
        rl_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == i2cms_pkg::ADDR_CTRL2 && reg_wdata_i[0])
        cnt_q <= 8'h00;
      else if (cnt_q != 8'hff)
        cnt_q <= cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hi; $past(sda_i, 3) && $past(scl_i, 3); endsequence
  sequence s_lo; !$past(sda_i, 3) && !$past(scl_i, 3) && !sda_i && !scl_i; endsequence
  sequence s_lost; (sda_oe_n_o && !sda_i && scl_i)[*4]; endsequence
  property p_rst; $fell(rst_i) |-> sda_oe_n_o && !wake_o && reg_rdata_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_drive; $fell(sda_oe_n_o) |-> s_hi; endproperty
  a_drive: assert property (p_drive) else $error("data pulled with a line low");
  property p_first; $fell(sda_oe_n_o) && cnt_q != 8'hff |->
    cnt_q >= {1'b0, rl_q[6:0]} && cnt_q <= {1'b0, rl_q[6:0]} + 8'h04; endproperty
  a_first: assert property (p_first) else $error("first start period wrong");
  property p_hold; $fell(sda_oe_n_o) |=> (!sda_oe_n_o)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("data line not held low");
  property p_lost; s_lost |=> sda_oe_n_o[*8]; endproperty
  a_lost: assert property (p_lost) else $error("data driven after lost bit");
  property p_abort; (reg_wr_i && reg_addr_i == i2cms_pkg::ADDR_CTRL2 && reg_wdata_i[0])
    ##0 s_lo |=> sda_oe_n_o[*8]; endproperty
  a_abort: assert property (p_abort) else $error("start not aborted");
  property p_wake; (slave_match_i || slave_byte_i) && c1_q[i2cms_pkg::CTRL1_IRQ_EN]
    && c1_q[i2cms_pkg::CTRL1_SLEEP] |-> ##[1:2] wake_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake request");
  property p_quiet; $rose(wake_o) |-> $past(c1_q[i2cms_pkg::CTRL1_IRQ_EN]); endproperty
  a_quiet: assert property (p_quiet) else $error("wake without enable");
endmodule // i2cms_checker
bind i2cms_core i2cms_checker i2cms_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rdata_o(reg_rdata_o), .sda_i(sda_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .slave_match_i(slave_match_i), .slave_byte_i(slave_byte_i), .wake_o(wake_o));

// File: sim/i2cms_bus_model.sv
// Model of the other masters and slaves sharing the two wired lines.
`timescale 1ns/100ps
module i2cms_bus_model (
  // Device line enables.
  input wire logic sda_oe_n_i,
  input wire logic scl_oe_n_i,
  // Other party controls.
  input wire logic hold_sda_i,
  input wire logic hold_scl_i,
  input wire logic run_i,
  // Wired lines with pull-ups.
  output logic sda_o,
  output logic scl_o
);
  logic clk_q = 1'b1;
  // The other master clocks only within a frame and leaves its clock high between.
  initial
  begin
    #13;
    forever #400 clk_q = run_i ? ~clk_q : 1'b1;
  end
  assign sda_o = sda_oe_n_i & ~hold_sda_i;
  assign scl_o = scl_oe_n_i & clk_q & ~hold_scl_i;
endmodule // i2cms_bus_model

// File: sim/i2c_master_start_arbitration_test.sv
// Self-checking bench of the start and arbitration core.
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module i2c_master_start_arbitration_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hs = 1'b0;
  logic hc = 1'b0;
  logic run = 1'b0;
  logic sm = 1'b0;
  logic sb = 1'b0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic sda;
  logic scl;
  logic oe_n;
  logic scl_oe_n;
  logic wake;
  int fails = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  i2cms_core i2cms_core_i (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sda_i(sda), .sda_o(), .sda_oe_n_o(oe_n),
    .scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n), .slave_match_i(sm), .slave_byte_i(sb),
    .wake_o(wake));
  i2cms_bus_model i2cms_bus_model_i (.sda_oe_n_i(oe_n), .scl_oe_n_i(scl_oe_n), .hold_sda_i(hs),
    .hold_scl_i(hc), .run_i(run), .sda_o(sda), .scl_o(scl));
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #500000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(i2cms_pkg::ADDR_RELOAD);
    `CHK("reload", i2cms_pkg::RELOAD_RST, d)
    rd_reg(3'h6);
    `CHK("unmapped", 8'h00, d)
    $display("test reset done");
    wr_reg(i2cms_pkg::ADDR_RELOAD, 8'h84);
    wr_reg(i2cms_pkg::ADDR_CTRL1, 8'h01);
    wr_reg(i2cms_pkg::ADDR_CTRL2, 8'h01);
    wr_reg(i2cms_pkg::ADDR_BUF, 8'h3c);
    wr_reg(i2cms_pkg::ADDR_CTRL2, 8'h04);
    for (int i = 0; i < 40 && oe_n !== 1'b0; i++) @(posedge clk);
    `CHK("drive", 1'b0, oe_n)
    repeat (4) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_STATUS);
    `CHK("seen", 1'b1, d[i2cms_pkg::STAT_START])
    rd_reg(i2cms_pkg::ADDR_CTRL2);
    `CHK("busy", 8'h01, d)
    rd_reg(i2cms_pkg::ADDR_FLAGS);
    `CHK("clash", 1'b1, d[i2cms_pkg::FLAG_WCLASH])
    repeat (140) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_CTRL2);
    `CHK("done", 8'h00, d)
    `CHK("held", 1'b0, oe_n)
    $display("test start done");
    hs <= 1'b1;
    run <= 1'b1;
    wr_reg(i2cms_pkg::ADDR_BUF, 8'h80);
    repeat (30) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_FLAGS);
    `CHK("coll", 1'b1, d[i2cms_pkg::FLAG_COLL])
    rd_reg(i2cms_pkg::ADDR_STATUS);
    `CHK("full", 1'b0, d[i2cms_pkg::STAT_FULL])
    `CHK("free", 1'b1, oe_n)
    run <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_FLAGS);
    `CHK("sticky", 1'b1, d[i2cms_pkg::FLAG_COLL])
    wr_reg(i2cms_pkg::ADDR_FLAGS, 8'h04);
    hs <= 1'b0;
    repeat (6) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_FLAGS);
    `CHK("event", 1'b1, d[i2cms_pkg::FLAG_EVENT])
    rd_reg(i2cms_pkg::ADDR_STATUS);
    `CHK("stop", 1'b1, d[i2cms_pkg::STAT_STOP])
    wr_reg(i2cms_pkg::ADDR_FLAGS, 8'h0f);
    $display("test collision done");
    hs <= 1'b1;
    hc <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(i2cms_pkg::ADDR_CTRL2, 8'h01);
    repeat (20) @(posedge clk);
    rd_reg(i2cms_pkg::ADDR_FLAGS);
    `CHK("low", 1'b1, d[i2cms_pkg::FLAG_COLL])
    rd_reg(i2cms_pkg::ADDR_CTRL2);
    `CHK("cleared", 1'b0, d[i2cms_pkg::CTRL2_START])
    `CHK("idle", 1'b1, oe_n)
    hc <= 1'b0;
    repeat (4) @(posedge clk);
    hs <= 1'b0;
    repeat (6) @(posedge clk);
    wr_reg(i2cms_pkg::ADDR_CTRL1, 8'h00);
    rd_reg(i2cms_pkg::ADDR_STATUS);
    `CHK("off", 2'b00, d[4:3])
    wr_reg(i2cms_pkg::ADDR_CTRL1, 8'h07);
    sm <= 1'b1;
    @(posedge clk);
    sm <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wake", 1'b1, wake)
    wr_reg(i2cms_pkg::ADDR_CTRL1, 8'h05);
    wr_reg(i2cms_pkg::ADDR_FLAGS, 8'h08);
    sb <= 1'b1;
    @(posedge clk);
    sb <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("asleep", 1'b0, wake)
    $display("test wake done");
    stop_test();
  end
endmodule // i2c_master_start_arbitration_test
